// ---- hw/ccr_pkg.sv ----
// constants and types of the charger control register bank
// Functional notes
// - table 0: 100mA, 500mA, 1A, unlimited
// - table 1: 100mA, 700mA, 700mA, unlimited
// - source bit 0: 100mA while the pin is enabled and matches its polarity bit, else 500mA
// - high impedance follows its bit, default off
// - code 0 is 3.5V, 20mV steps
// - from code 41 upward, 30mV steps
package ccr_pkg;
	localparam logic [7:0] ADDR_LIMIT_MODE = 8'h01;
	localparam logic [7:0] ADDR_VREG_PIN   = 8'h02;
	localparam logic [7:0] ADDR_TABLE_SEL  = 8'h06;
	localparam logic [7:0] RESET_LIMIT_MODE = 8'h40;
	localparam logic [7:0] RESET_VREG_PIN   = 8'h8E;
	localparam logic       RESET_TABLE_SEL  = 1'h0;
	// field positions, limit and mode register
	localparam int LIMIT_CODE_LSB = 6;
	localparam int TERM_SHDN_BIT  = 5;
	localparam int END_SENSE_BIT  = 3;
	localparam int SOURCE_BIT     = 2;
	localparam int HIGHZ_BIT      = 1;
	localparam int OPMODE_BIT     = 0;
	// field positions, voltage and pin register and table select register
	localparam int VREG_CODE_LSB  = 2;
	localparam int PIN_POL_BIT    = 1;
	localparam int PIN_EN_BIT     = 0;
	localparam int TABLE_SEL_BIT  = 7;
	// regulation target in millivolts
	localparam logic [12:0] VREG_BASE_MV  = 13'h0DAC;
	localparam logic [12:0] VREG_STEP_LO  = 13'h0014;
	localparam logic [12:0] VREG_STEP_HI  = 13'h001E;
	localparam logic [5:0]  VREG_KNEE     = 6'h29;
	typedef enum logic [2:0] {
		CCR_LIM_100 = 3'b001,
		CCR_LIM_500 = 3'b010,
		CCR_LIM_700 = 3'b011,
		CCR_LIM_1A  = 3'b100,
		CCR_LIM_OFF = 3'b111
	} ccr_limit_type;
	typedef struct packed {
		ccr_limit_type input_limit;
		logic          charge_end_sensing;
		logic          term_shutdown_enable;
		logic          high_impedance;
		logic          operating_mode_select;
		logic [12:0]   regulation_mv;
		logic [5:0]    regulation_voltage_code;
	} ccr_ctrl_type;
endpackage : ccr_pkg

// ---- hw/ccr_regs.sv ----
// charger control registers and their decoded controls
`timescale 1ns/1ps
module ccr_regs (
	// clock and reset
	input  wire logic          clock_i,
	input  wire logic          reset_n_i,
	// register access port
	input  wire logic          reg_write_i,
	input  wire logic [7:0]    reg_addr_i,
	input  wire logic [7:0]    reg_wdata_i,
	output logic      [7:0]    reg_rdata_o,
	// external pin
	input  wire logic          otg_pin_i,
	// decoded controls
	output ccr_pkg::ccr_ctrl_type ctrl_o
);
	logic [7:0] limit_mode;
	logic [7:0] vreg_pin;
	logic       limit_table_select;
	logic [7:0] next_limit_mode;
	logic [7:0] next_vreg_pin;
	logic       next_limit_table_select;
	logic [7:0] next_rdata;
	ccr_pkg::ccr_ctrl_type next_ctrl;

	always_comb begin
		next_limit_mode = limit_mode;
		next_vreg_pin = vreg_pin;
		next_limit_table_select = limit_table_select;
		if (reg_write_i) begin
			unique case (reg_addr_i)
				ccr_pkg::ADDR_LIMIT_MODE: next_limit_mode = reg_wdata_i;
				ccr_pkg::ADDR_VREG_PIN: next_vreg_pin = reg_wdata_i;
				ccr_pkg::ADDR_TABLE_SEL: begin
					next_limit_table_select =
						reg_wdata_i[ccr_pkg::TABLE_SEL_BIT];
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			limit_mode <= ccr_pkg::RESET_LIMIT_MODE;
			vreg_pin <= ccr_pkg::RESET_VREG_PIN;
			limit_table_select <= ccr_pkg::RESET_TABLE_SEL;
		end else begin
			limit_mode <= next_limit_mode;
			vreg_pin <= next_vreg_pin;
			limit_table_select <= next_limit_table_select;
		end
	end

	// read mux; only the table bit is held of the shared register
	always_comb begin
		unique case (reg_addr_i)
			ccr_pkg::ADDR_LIMIT_MODE: next_rdata = limit_mode;
			ccr_pkg::ADDR_VREG_PIN: next_rdata = vreg_pin;
			ccr_pkg::ADDR_TABLE_SEL: begin
				next_rdata = {limit_table_select, 7'h00};
			end
			default: next_rdata = 8'h00;
		endcase
	end

	// read data from a flop; it lags the address by one edge
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			reg_rdata_o <= 8'h00;
		end else begin
			reg_rdata_o <= next_rdata;
		end
	end

	// decode of fields into controls
	always_comb begin
		logic [1:0] code;
		logic [5:0] vcode;
		logic       pin_asserted;
		code = limit_mode[ccr_pkg::LIMIT_CODE_LSB +: 2];
		vcode = vreg_pin[ccr_pkg::VREG_CODE_LSB +: 6];
		pin_asserted = vreg_pin[ccr_pkg::PIN_EN_BIT] &
			~(otg_pin_i ^ vreg_pin[ccr_pkg::PIN_POL_BIT]);
		next_ctrl = '0;
		if (!limit_mode[ccr_pkg::SOURCE_BIT]) begin
			next_ctrl.input_limit = pin_asserted ?
				ccr_pkg::CCR_LIM_100 : ccr_pkg::CCR_LIM_500;
		end else if (!limit_table_select) begin
			unique case (code)
				2'h0: next_ctrl.input_limit = ccr_pkg::CCR_LIM_100;
				2'h1: next_ctrl.input_limit = ccr_pkg::CCR_LIM_500;
				2'h2: next_ctrl.input_limit = ccr_pkg::CCR_LIM_1A;
				2'h3: next_ctrl.input_limit = ccr_pkg::CCR_LIM_OFF;
			endcase
		end else begin
			unique case (code)
				2'h0: next_ctrl.input_limit = ccr_pkg::CCR_LIM_100;
				2'h1: next_ctrl.input_limit = ccr_pkg::CCR_LIM_700;
				2'h2: next_ctrl.input_limit = ccr_pkg::CCR_LIM_700;
				2'h3: next_ctrl.input_limit = ccr_pkg::CCR_LIM_OFF;
			endcase
		end
		next_ctrl.charge_end_sensing = limit_mode[ccr_pkg::END_SENSE_BIT];
		next_ctrl.term_shutdown_enable =
			limit_mode[ccr_pkg::TERM_SHDN_BIT];
		next_ctrl.high_impedance = limit_mode[ccr_pkg::HIGHZ_BIT];
		next_ctrl.operating_mode_select = limit_mode[ccr_pkg::OPMODE_BIT];
		next_ctrl.regulation_voltage_code = vcode;
		if (vcode < ccr_pkg::VREG_KNEE) begin
			next_ctrl.regulation_mv = 13'(ccr_pkg::VREG_BASE_MV +
				13'(vcode) * ccr_pkg::VREG_STEP_LO);
		end else begin
			next_ctrl.regulation_mv = 13'(ccr_pkg::VREG_BASE_MV +
				13'(ccr_pkg::VREG_KNEE - 6'h01) * ccr_pkg::VREG_STEP_LO +
				13'(vcode - ccr_pkg::VREG_KNEE + 6'h01) *
				ccr_pkg::VREG_STEP_HI);
		end
	end

	// controls registered so the outputs come from flip-flops
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ctrl_o <= '0;
		end else begin
			ctrl_o <= next_ctrl;
		end
	end
endmodule : ccr_regs

// ---- testbench/ccr_host.sv ----
// host model driving the register port
`timescale 1ns/1ps
module ccr_host (
	// clock
	input  wire logic       clock_i,
	// register access drive
	output logic            w_o = 1'h0,
	output logic      [7:0] a_o = 8'h00,
	output logic      [7:0] d_o = 8'h00
);
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock_i);
		#1 {w_o, a_o, d_o} = {1'h1, a, d};
		@(posedge clock_i);
		// released data must not look valid
		#1 {w_o, d_o} = {1'h0, ~d};
	endtask : wr
	// read data is registered, so wait one edge after the address
	task sel(input logic [7:0] a);
		@(posedge clock_i);
		#1 a_o = a;
		@(posedge clock_i);
		#1;
	endtask : sel
endmodule : ccr_host

// ---- testbench/ccr_regs_chk.sv ----
// port checks of the register bank
`timescale 1ns/1ps
module ccr_regs_chk (
	// clock and reset
	input wire logic                  clock_i,
	input wire logic                  reset_n_i,
	// register access port
	input wire logic                  reg_write_i,
	input wire logic [7:0]            reg_addr_i,
	input wire logic [7:0]            reg_wdata_i,
	// decoded controls
	input wire ccr_pkg::ccr_ctrl_type ctrl_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!reset_n_i);
	wire        w1 = reg_write_i && reg_addr_i == 8'h01;
	wire        w2 = reg_write_i && reg_addr_i == 8'h02;
	wire [2:0]  li = ctrl_o.input_limit;
	wire [5:0]  vc = ctrl_o.regulation_voltage_code;
	wire [12:0] mv = ctrl_o.regulation_mv;
	chk_highz_follow: assert property (w1 |=> ##1
		ctrl_o.high_impedance == $past(reg_wdata_i[1], 2))
		else $error("highz");
	chk_end_sense: assert property (w1 |=> ##1
		ctrl_o.charge_end_sensing == $past(reg_wdata_i[3], 2))
		else $error("end_sense");
	chk_lim_none: assert property (w1 && reg_wdata_i[7:6] == 2'h3
		&& reg_wdata_i[2] |=> ##1 li == 3'h7) else $error("none");
	chk_lim_low: assert property (w1 && reg_wdata_i[7:6] == 2'h0
		&& reg_wdata_i[2] |=> ##1 li == 3'h1) else $error("low");
	chk_pin_path: assert property (w1 && !reg_wdata_i[2] |=> ##1
		li inside {3'h1, 3'h2}) else $error("pin");
	chk_vreg_low: assert property ($past(reset_n_i) && vc <= 6'h28
		|-> mv == 13'h0DAC + 13'h0014 * vc) else $error("vlo");
	chk_vreg_high: assert property (vc > 6'h28 |->
		mv == 13'h10CC + 13'h001E * (vc - 6'h28)) else $error("vhi");
	chk_code_load: assert property (w2 |=> ##1
		vc == $past(reg_wdata_i[7:2], 2)) else $error("code");
endmodule : ccr_regs_chk

// ---- testbench/charger_control_regs_tb_top.sv ----
// bench for the charger control register bank
`timescale 1ns/1ps
module charger_control_regs_tb_top;
	logic clk = 1'h0, rst_n = 1'h0, pin = 1'h0, w;
	logic [7:0] a, d, q;
	ccr_pkg::ccr_ctrl_type c;
	int n_fail = 0, checks = 0;
	always #2 clk = ~clk;
	ccr_host H (.clock_i(clk), .w_o(w), .a_o(a), .d_o(d));
	ccr_regs DUT (.clock_i(clk), .reset_n_i(rst_n), .reg_write_i(w),
		.reg_addr_i(a), .reg_wdata_i(d), .reg_rdata_o(q),
		.otg_pin_i(pin), .ctrl_o(c));
	task cmp(string n, logic [12:0] e, logic [12:0] g);
		checks++;
		if (g !== e) begin
			n_fail++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask : cmp
	task wrap_up;
		$display("checks %0d fails %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : wrap_up
	task put(logic [7:0] ra, logic [7:0] rd);
		H.wr(ra, rd);
		@(posedge clk);
		#1;
	endtask : put
	task t_reset;
		logic [7:0] aa [4] = '{8'h01, 8'h02, 8'h06, 8'h10};
		logic [7:0] ea [4] = '{8'h40, 8'h8E, 8'h00, 8'h00};
		for (int i = 0; i < 4; i++) begin
			H.sel(aa[i]);
			cmp("rd", 13'(ea[i]), 13'(q));
		end
		cmp("mv", 13'h1068, c.regulation_mv);
		$display("reset done");
	endtask : t_reset
	task t_table;
		logic [2:0] li [8] = '{3'h1, 3'h2, 3'h4, 3'h7,
			3'h1, 3'h3, 3'h3, 3'h7};
		for (int i = 0; i < 8; i++) begin
			put(8'h06, {i[2], 7'h00});
			put(8'h01, {i[1:0], 6'h04});
			cmp("lim", 13'(li[i]), 13'(c.input_limit));
		end
		$display("table done");
	endtask : t_table
	task t_pin;
		put(8'h01, 8'h0A);
		cmp("highz", 13'h1, 13'(c.high_impedance));
		cmp("end_sense", 13'h1, 13'(c.charge_end_sensing));
		for (int i = 0; i < 8; i++) begin
			pin = i[0];
			put(8'h02, {6'h23, i[2:1]});
			cmp("pin", i[1] && i[0] == i[2] ? 13'h1 : 13'h2,
				13'(c.input_limit));
		end
		$display("pin done");
	endtask : t_pin
	task t_volt;
		int v [4] = '{0, 40, 41, 63};
		for (int i = 0; i < 4; i++) begin
			put(8'h02, {v[i][5:0], 2'h2});
			cmp("mv", 13'(v[i] > 40 ? 4300 + (v[i] - 40) * 30 :
				3500 + v[i] * 20), c.regulation_mv);
		end
		$display("volt done");
	endtask : t_volt
	task t_rback;
		put(8'h01, 8'h31);
		cmp("tsd", 13'h1, 13'(c.term_shutdown_enable));
		cmp("opm", 13'h1, 13'(c.operating_mode_select));
		cmp("highz", 13'h0, 13'(c.high_impedance));
		cmp("end_sense", 13'h0, 13'(c.charge_end_sensing));
		put(8'h06, 8'hFF);
		put(8'h10, 8'h5A);
		H.sel(8'h01);
		cmp("rd", 13'h31, 13'(q));
		H.sel(8'h02);
		cmp("rd", 13'hFE, 13'(q));
		cmp("code", 13'h3F, 13'(c.regulation_voltage_code));
		H.sel(8'h06);
		cmp("rd", 13'h80, 13'(q));
		H.sel(8'h10);
		cmp("rd", 13'h00, 13'(q));
		// mid-run reset must bring back every default
		rst_n = 1'h0;
		repeat (2) @(posedge clk);
		#1 rst_n = 1'h1;
		t_reset;
		cmp("lim", 13'h2, 13'(c.input_limit));
		$display("readback done");
	endtask : t_rback
	initial begin
		repeat (20) @(posedge clk);
		#1 rst_n = 1'h1;
		t_reset;
		t_table;
		t_pin;
		t_volt;
		t_rback;
		wrap_up;
	end
	initial begin
		#4000;
		n_fail++;
		wrap_up;
	end
endmodule : charger_control_regs_tb_top
bind ccr_regs ccr_regs_chk CHK (.clock_i, .reset_n_i, .reg_write_i,
	.reg_addr_i, .reg_wdata_i, .ctrl_o);
